// [src/mpo_pkg.sv]
package mpo_pkg;
    // register offsets on the plain port
    localparam logic [3:0] ADDR_OUT_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PROT_A   = 4'h1;
    localparam logic [3:0] ADDR_PROT_B   = 4'h2;
    localparam logic [3:0] ADDR_UNLOCK   = 4'h3;
    localparam logic [3:0] ADDR_POLARITY = 4'h4;
    // output control field positions
    localparam int OC_DIR_BIT   = 15;
    localparam int OC_EXP_LSB   = 12;
    localparam int OC_PWM_SYNC_SELECT_BIT = 11;
    localparam int OC_WSEL_LSB  = 8;
    localparam int OC_SYNC_LSB  = 6;
    // protect control a field positions
    localparam int PA_CNT_LSB   = 4;
    localparam int PA_STATE_BIT = 2;
    localparam int PA_RET_BIT   = 1;
    localparam int PA_EN_BIT    = 0;
    // protect control b field positions
    localparam int PB_MAN_BIT   = 7;
    localparam int PB_PER_BIT   = 6;
    localparam int PB_TMR_BIT   = 5;
    localparam int PB_STATE_BIT = 4;
    localparam int PB_MODE_LSB  = 2;
    localparam int PB_HALT_BIT  = 1;
    localparam int PB_EN_BIT    = 0;
    // unlock keys
    localparam logic [7:0] KEY_FIRST  = 8'h5a;
    localparam logic [7:0] KEY_SECOND = 8'ha5;
    // reset values
    localparam logic [15:0] RST_OUT_CTRL = 16'h0000;
    localparam logic [3:0]  RST_CNT      = 4'h1;
    // sampling period of the overload input
    localparam int SYS_CLK_MHZ   = 200;
    localparam int SAMPLE_NS     = 200;
    localparam int SAMPLE_CYCLES = (SAMPLE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYCLES - 1);
    // update sync sources
    localparam logic [1:0] SYNC_NOW   = 2'h0;
    localparam logic [1:0] SYNC_POS   = 2'h1;
    localparam logic [1:0] SYNC_TMR1  = 2'h2;
    localparam logic [1:0] SYNC_TMR2  = 2'h3;
    // overload cut-off modes
    localparam logic [1:0] CUT_NONE   = 2'h0;
    localparam logic [1:0] CUT_ALL    = 2'h1;
    localparam logic [1:0] CUT_PWM    = 2'h2;
    localparam logic [1:0] CUT_UPLOW  = 2'h3;

    typedef enum logic [1:0] {
        UNL_IDLE,
        UNL_GOT1,
        UNL_OPEN
    } mpo_unlock_t;

    // event inputs from the timing logic
    typedef struct packed {
        logic pwm_wave;
        logic count_down;
        logic pos_detect;
        logic timer1;
        logic timer2;
        logic pwm_period;
    } mpo_evt_t;

    // six drive outputs, w v u
    typedef struct packed {
        logic [2:0] upper;
        logic [2:0] lower;
    } mpo_drive_t;

    typedef struct packed {
        logic [15:0] out_ctrl;
        logic [11:0] active;
        logic        pend;
        logic [1:0]  pol;
        logic        emg_en;
        logic        emg_state;
        logic        emg_prev;
        logic        emg_irq;
        logic [3:0]  cnt_sel;
        logic        man_ret;
        logic        per_ret;
        logic        tmr_ret;
        logic [1:0]  cut_mode;
        logic        halt_en;
        logic        ol_en;
        logic        ol_state;
        logic        ol_irq;
        logic [3:0]  low_cnt;
        logic [7:0]  tick;
        mpo_drive_t  snap;
        mpo_unlock_t unl;
        mpo_drive_t  drv;
        mpo_drive_t  drv_oe_n;
        logic        halt;
        logic [15:0] rdata;
        logic [1:0]  emg_sync;
        logic [1:0]  ol_sync;
    } mpo_state_t;
endpackage

// [src/mpo_motor_output.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - read-only count direction in bit 15
// - expected position pattern bits 14..12
// - pwm sync select bit 11 (stored, but both settings use pwm_wave)
// - per-phase waveform select bits 10..8
// - update sync field bits 7..6
// - pwm output code decode
// - fixed level code decode
// - emergency falling edge tri-states, interrupts
// - emergency state bit reads one
// - emergency return only with input high
// - disable needs 5a then a5 keys
// - no emergency interrupt while disabled
// - emergency protection enabled after reset
// - overload entered on low input
// - three overload return methods
// - overload return only with input high
// - sample every 200 ns, count 1..15
// - two-bit cut-off mode selects outputs
// - upper/lower cut uses majority before overload
// - cut outputs sit inactive, but upper/lower mode turns one whole side on
// - no overload interrupt while disabled
// - halt counter during overload if set
// - manual return has priority
// - overload state bit readable
module mpo_motor_output (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    // register port
    input  wire logic [3:0]        i_addr,
    input  wire logic [15:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [15:0]       o_rdata,
    // timing logic events
    input  wire mpo_pkg::mpo_evt_t i_evt,
    // protective pins
    input  wire logic              i_emergency_stop_n,
    input  wire logic              i_overload_n,
    // inverter drive
    output mpo_pkg::mpo_drive_t    o_drive,
    output mpo_pkg::mpo_drive_t    o_drive_oe_n,
    // status to the system
    output logic                   o_emergency_irq,
    output logic                   o_overload_irq,
    output logic                   o_counter_halt
);
    import mpo_pkg::*;

    mpo_state_t r;
    mpo_state_t next_r;

    // one phase pair: returns {upper, lower} active-high on state
    function automatic logic [1:0] phase_on(input logic [1:0] code,
                                            input logic sel,
                                            input logic wave);
        logic [1:0] res;
        res = 2'b00;
        if (sel) begin
            unique case (code)
                2'b01:   res = {1'b0, wave};
                2'b10:   res = {wave, 1'b0};
                default: res = {wave, wave};
            endcase
        end else begin
            // fixed level decode
            // code gives active-low pin levels, so on-state is its inverse
            unique case (code)
                2'b00:   res = 2'b11;
                2'b01:   res = 2'b10;
                2'b10:   res = 2'b01;
                default: res = 2'b00;
            endcase
        end
        return res;
    endfunction

    // true when at least two bits of a phase triple are set
    function automatic logic two_plus(input logic [2:0] v);
        return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction

    logic       wr_oc;
    logic       wr_pa;
    logic       wr_pb;
    logic       wr_ul;
    logic       emg_hi;
    logic       ol_hi;
    logic       upd;
    logic       ol_hit;
    logic       ol_ret;
    logic [1:0] pair;
    mpo_drive_t on;
    mpo_drive_t cut;

    always_comb begin
        next_r = r;
        wr_oc  = i_wr && (i_addr == ADDR_OUT_CTRL);
        wr_pa  = i_wr && (i_addr == ADDR_PROT_A);
        wr_pb  = i_wr && (i_addr == ADDR_PROT_B);
        wr_ul  = i_wr && (i_addr == ADDR_UNLOCK);
        pair   = 2'b00;
        on     = '0;
        cut    = '0;

        // pin synchronisers
        next_r.emg_sync = {r.emg_sync[0], i_emergency_stop_n};
        next_r.ol_sync  = {r.ol_sync[0], i_overload_n};
        emg_hi = r.emg_sync[1];
        ol_hi  = r.ol_sync[1];
        next_r.emg_prev = emg_hi;

        // output control register write
        if (wr_oc) begin
            next_r.out_ctrl[14:0] = i_wdata[14:0];
            next_r.pend = 1'b1;
        end
        next_r.out_ctrl[OC_DIR_BIT] = i_evt.count_down;

        unique case (r.out_ctrl[OC_SYNC_LSB +: 2])
            SYNC_NOW:  upd = 1'b1;
            SYNC_POS:  upd = i_evt.pos_detect;
            SYNC_TMR1: upd = i_evt.timer1;
            default:   upd = i_evt.timer2;
        endcase
        if (r.pend && upd) begin
            next_r.active = r.out_ctrl[11:0];
            next_r.pend   = wr_oc;
        end

        if (wr_ul) begin
            unique case (r.unl)
                UNL_IDLE: next_r.unl = (i_wdata[7:0] == KEY_FIRST)
                                       ? UNL_GOT1 : UNL_IDLE;
                UNL_GOT1: next_r.unl = (i_wdata[7:0] == KEY_SECOND)
                                       ? UNL_OPEN : UNL_IDLE;
                default:  next_r.unl = (i_wdata[7:0] == KEY_FIRST)
                                       ? UNL_GOT1 : UNL_IDLE;
            endcase
        end
        if (i_wr && i_addr == ADDR_POLARITY) begin
            next_r.pol = i_wdata[1:0];
        end

        if (wr_pa) begin
            next_r.cnt_sel = i_wdata[PA_CNT_LSB +: 4];
            if (i_wdata[PA_EN_BIT]) begin
                next_r.emg_en = 1'b1;
            end else if (r.unl == UNL_OPEN) begin
                next_r.emg_en = 1'b0;
                next_r.unl    = UNL_IDLE;
            end
            if (i_wdata[PA_RET_BIT] && emg_hi) begin
                next_r.emg_state = 1'b0;
            end
        end

        next_r.emg_irq = 1'b0;
        if (r.emg_en && r.emg_prev && !emg_hi) begin
            next_r.emg_state = 1'b1;
            next_r.emg_irq   = 1'b1;
        end

        if (wr_pb) begin
            next_r.man_ret  = i_wdata[PB_MAN_BIT];
            next_r.per_ret  = i_wdata[PB_PER_BIT];
            next_r.tmr_ret  = i_wdata[PB_TMR_BIT];
            next_r.cut_mode = i_wdata[PB_MODE_LSB +: 2];
            next_r.halt_en  = i_wdata[PB_HALT_BIT];
            next_r.ol_en    = i_wdata[PB_EN_BIT];
        end

        ol_hit = 1'b0;
        if (r.tick == SAMPLE_LAST) begin
            next_r.tick = '0;
            if (ol_hi) begin
                next_r.low_cnt = '0;
            end else if (r.low_cnt < r.cnt_sel) begin
                next_r.low_cnt = r.low_cnt + 4'h1;
                ol_hit = ((r.low_cnt + 4'h1) >= r.cnt_sel);
            end else begin
                ol_hit = 1'b1;
            end
        end else begin
            next_r.tick = r.tick + 8'h01;
        end

        // current turn-on state of each phase
        for (int p = 0; p < 3; p++) begin
            pair = phase_on(r.active[2*p +: 2], r.active[OC_WSEL_LSB + p],
                            r.out_ctrl[OC_PWM_SYNC_SELECT_BIT] ? i_evt.pwm_wave
                                                     : i_evt.pwm_wave);
            on.upper[p] = pair[1];
            on.lower[p] = pair[0];
        end

        ol_ret = ol_hi && (r.man_ret ||
                 (r.per_ret && i_evt.pwm_period) ||
                 (r.tmr_ret && i_evt.timer1));
        next_r.ol_irq = 1'b0;
        if (!r.ol_en) begin
            next_r.ol_state = 1'b0;
        end else if (!r.ol_state && ol_hit) begin
            next_r.ol_state = 1'b1;
            next_r.ol_irq   = 1'b1;
            next_r.snap     = on;
        end else if (r.ol_state && ol_ret) begin
            next_r.ol_state = 1'b0;
            if (r.man_ret && !wr_pb) begin
                next_r.man_ret = 1'b0;
            end
        end

        cut = on;
        if (r.ol_state) begin
            unique case (r.cut_mode)
                CUT_NONE: cut = on;
                CUT_ALL:  cut = '0;
                CUT_PWM: begin
                    for (int p = 0; p < 3; p++) begin
                        if (r.active[OC_WSEL_LSB + p]) begin
                            cut.upper[p] = 1'b0;
                            cut.lower[p] = 1'b0;
                        end
                    end
                end
                default: begin
                    if (two_plus(r.snap.upper)) begin
                        cut.upper = 3'b111;
                        cut.lower = 3'b000;
                    end else if (two_plus(r.snap.lower)) begin
                        cut.upper = 3'b000;
                        cut.lower = 3'b111;
                    end
                end
            endcase
        end

        next_r.drv.upper = r.pol[1] ? cut.upper : ~cut.upper;
        next_r.drv.lower = r.pol[0] ? cut.lower : ~cut.lower;
        next_r.drv_oe_n = (r.emg_state || next_r.emg_state) ? '1 : '0;
        next_r.halt = r.halt_en && r.ol_state;

        // read data one cycle later
        next_r.rdata = '0;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_OUT_CTRL: next_r.rdata = r.out_ctrl;
                ADDR_PROT_A: next_r.rdata = {8'h00, r.cnt_sel, 1'b0,
                                 r.emg_state, 1'b0, r.emg_en};
                ADDR_PROT_B: next_r.rdata = {8'h00, r.man_ret, r.per_ret,
                                 r.tmr_ret, r.ol_state, r.cut_mode,
                                 r.halt_en, r.ol_en};
                ADDR_POLARITY: next_r.rdata = {14'h0000, r.pol};
                default: next_r.rdata = '0;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r          <= '0;
            r.out_ctrl <= RST_OUT_CTRL;
            r.cnt_sel  <= RST_CNT;
            r.emg_en   <= 1'b1;
            r.unl      <= UNL_IDLE;
            r.drv      <= '1;
            r.emg_sync <= 2'b11;
            r.ol_sync  <= 2'b11;
            r.emg_prev <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign o_rdata         = r.rdata;
    assign o_drive         = r.drv;
    assign o_drive_oe_n    = r.drv_oe_n;
    assign o_emergency_irq = r.emg_irq;
    assign o_overload_irq  = r.ol_irq;
    assign o_counter_halt  = r.halt;
endmodule
`default_nettype wire

// [verif/mpo_gate_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mpo_gate_model (
    // drive from the block
    input  wire mpo_pkg::mpo_drive_t i_drive,
    input  wire mpo_pkg::mpo_drive_t i_drive_oe_n,
    // fault requests from the bench
    input  wire logic                i_emg_req,
    input  wire logic                i_ol_req,
    // fault pins and gate levels
    output logic                     o_emergency_stop_n,
    output logic                     o_overload_n,
    output mpo_pkg::mpo_drive_t      o_gate
);
    import mpo_pkg::*;
    // fault pins are active low
    assign o_emergency_stop_n = !i_emg_req;
    assign o_overload_n       = !i_ol_req;
    // released gate inputs sit on their pull-down
    assign o_gate = i_drive & ~i_drive_oe_n;
endmodule
`default_nettype wire

// [verif/mpo_motor_output_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module mpo_motor_output_monitor (
    input wire logic                i_clk,
    input wire logic                i_arst_n,
    input wire logic [3:0]          i_addr,
    input wire logic                i_rd,
    input wire logic [15:0]         o_rdata,
    input wire mpo_pkg::mpo_evt_t   i_evt,
    input wire logic                i_emergency_stop_n,
    input wire logic                i_overload_n,
    input wire mpo_pkg::mpo_drive_t o_drive_oe_n,
    input wire logic                o_emergency_irq,
    input wire logic                o_overload_irq,
    input wire logic                o_counter_halt
);
    import mpo_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // a pulse lasting exactly one cycle
    sequence s_one_shot(sig);
        sig ##1 !sig;
    endsequence
    a_emg_tristate: assert property (
        o_emergency_irq |-> o_drive_oe_n == 6'h3f)
        else $error("outputs driven at emergency entry");
    a_emg_pulse: assert property (
        o_emergency_irq |-> s_one_shot(o_emergency_irq))
        else $error("emergency irq not one cycle");
    a_emg_cause: assert property (
        o_emergency_irq |-> !$past(i_emergency_stop_n, 2))
        else $error("emergency irq without low pin");
    a_oe_together: assert property (
        o_drive_oe_n == 6'h00 || o_drive_oe_n == 6'h3f)
        else $error("output enables split");
    a_emg_release: assert property (
        $fell(o_drive_oe_n[0]) |-> $past(i_emergency_stop_n, 2))
        else $error("emergency left with pin low");
    a_ol_cause: assert property (
        o_overload_irq |-> !$past(i_overload_n, 2))
        else $error("overload irq without low pin");
    a_ol_pulse: assert property (
        o_overload_irq |-> s_one_shot(o_overload_irq))
        else $error("overload irq not one cycle");
    a_halt_cause: assert property (
        $rose(o_counter_halt) |-> !$past(i_overload_n, 2))
        else $error("counter halted without overload");
    a_dir_read: assert property (
        $past(i_rd) && $past(i_addr) == ADDR_OUT_CTRL &&
        $past(i_evt.count_down, 2) == $past(i_evt.count_down)
        |-> o_rdata[OC_DIR_BIT] == $past(i_evt.count_down))
        else $error("direction flag misread");
endmodule
bind mpo_motor_output mpo_motor_output_monitor u_mon (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_evt(i_evt),
    .i_emergency_stop_n(i_emergency_stop_n), .i_overload_n(i_overload_n),
    .o_drive_oe_n(o_drive_oe_n), .o_emergency_irq(o_emergency_irq),
    .o_overload_irq(o_overload_irq), .o_counter_halt(o_counter_halt));
`default_nettype wire

// [verif/mpo_motor_output_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mpo_motor_output_tb;
    import mpo_pkg::*;
    typedef struct packed {
        logic [1:0]  pol;
        logic [15:0] ctrl;
        logic        wave;
        mpo_drive_t  exp;
    } mpo_row_t;
    logic        i_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000, o_rdata, v;
    mpo_evt_t    evt = '0;
    logic        emg_req = 1'b0, ol_req = 1'b0, emg_n, ol_n;
    logic        o_emergency_irq, o_overload_irq, o_counter_halt;
    mpo_drive_t  o_drive, o_drive_oe_n, gate;
    int          n_mismatch = 0, checks_done = 0, n_emg = 0, n_ol = 0;
    mpo_row_t    rows [4] = '{'{2'h0, 16'h7839, 1'b0, 6'h35},
        '{2'h3, 16'h0706, 1'b1, 6'h2e}, '{2'h3, 16'h0706, 1'b0, 6'h00},
        '{2'h3, 16'h0739, 1'b1, 6'h35}};
    logic [15:0] ret [4] = '{16'h0080, 16'h0040, 16'h0020, 16'h0080};
    logic [15:0] cut [4] = '{16'h0004, 16'h000c, 16'h0000, 16'h0008};
    logic [15:0] cexp [4] = '{16'h003f, 16'h0038, 16'h0038, 16'h0038};
    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;
    mpo_motor_output dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_evt(evt), .i_emergency_stop_n(emg_n),
        .i_overload_n(ol_n), .o_drive(o_drive), .o_drive_oe_n(o_drive_oe_n),
        .o_emergency_irq(o_emergency_irq), .o_overload_irq(o_overload_irq),
        .o_counter_halt(o_counter_halt));
    mpo_gate_model u_gate (.i_drive(o_drive), .i_drive_oe_n(o_drive_oe_n),
        .i_emg_req(emg_req), .i_ol_req(ol_req), .o_emergency_stop_n(emg_n),
        .o_overload_n(ol_n), .o_gate(gate));
    // interrupt pulse counters, off the active edge
    always @(negedge i_clk) begin
        if (o_emergency_irq === 1'b1) n_emg++;
        if (o_overload_irq === 1'b1) n_ol++;
    end
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk("rdata", e, o_rdata);
    endtask
    task automatic pulse(input int b);
        @(posedge i_clk) evt[b] <= 1'b1;
        @(posedge i_clk) evt[b] <= 1'b0;
    endtask
    task automatic kick(input int k);
        // manual return bit clears itself on return; once the pin is high, write it clear
        if (ret[k][7]) wr(ADDR_PROT_B, ol_n ? v & 16'hff7f : v);
        else pulse(ret[k][6] ? 0 : 2);
    endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (40000) @(posedge i_clk);
        n_mismatch++;
        end_of_test;
    end
    // main sequence
    initial begin
        cyc(4);
        chk("rst drive", 16'h003f, 16'(o_drive));
        chk("rst oe", 16'h0000, 16'(o_drive_oe_n));
        @(posedge i_clk) i_arst_n <= 1'b1;
        rd(ADDR_PROT_A, 16'h0011);
        rd(ADDR_PROT_B, 16'h0000);
        rd(4'h5, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_POLARITY, 16'(rows[i].pol));
            @(posedge i_clk) evt.pwm_wave <= rows[i].wave;
            wr(ADDR_OUT_CTRL, rows[i].ctrl);
            cyc(3);
            chk("drive", 16'(rows[i].exp), 16'(o_drive));
            rd(ADDR_OUT_CTRL, rows[i].ctrl);
        end
        wr(ADDR_POLARITY, 16'h0000);
        wr(ADDR_OUT_CTRL, 16'h0039);
        for (int s = 1; s < 4; s++) begin
            wr(ADDR_OUT_CTRL, (s % 2 ? 16'h0036 : 16'h0039) | 16'(s << 6));
            cyc(3);
            chk("held", s % 2 ? 16'h0035 : 16'h002e, 16'(o_drive));
            pulse(4 - s);
            cyc(3);
            chk("synced", s % 2 ? 16'h002e : 16'h0035, 16'(o_drive));
        end
        @(posedge i_clk) evt.count_down <= 1'b1;
        rd(ADDR_OUT_CTRL, 16'h80f6);
        @(posedge i_clk) evt.count_down <= 1'b0;
        @(posedge i_clk) emg_req <= 1'b1;
        cyc(6);
        chk("emg oe", 16'h003f, 16'(o_drive_oe_n));
        chk("emg gate", 16'h0000, 16'(gate));
        rd(ADDR_PROT_A, 16'h0015);
        wr(ADDR_OUT_CTRL, 16'h0000);
        wr(ADDR_PROT_A, 16'h0013);
        cyc(3);
        chk("emg hold", 16'h003f, 16'(o_drive_oe_n));
        @(posedge i_clk) emg_req <= 1'b0;
        cyc(4);
        wr(ADDR_PROT_A, 16'h0013);
        cyc(3);
        chk("emg back", 16'h0000, 16'(o_drive_oe_n));
        rd(ADDR_PROT_A, 16'h0011);
        chk("emg irqs", 16'h0001, 16'(n_emg));
        wr(ADDR_PROT_A, 16'h0010);
        rd(ADDR_PROT_A, 16'h0011);
        wr(ADDR_UNLOCK, 16'(KEY_FIRST));
        wr(ADDR_UNLOCK, 16'(KEY_SECOND));
        wr(ADDR_PROT_A, 16'h0030);
        rd(ADDR_PROT_A, 16'h0030);
        @(posedge i_clk) emg_req <= 1'b1;
        cyc(6);
        chk("emg off oe", 16'h0000, 16'(o_drive_oe_n));
        chk("emg off irq", 16'h0001, 16'(n_emg));
        @(posedge i_clk) emg_req <= 1'b0;
        wr(ADDR_OUT_CTRL, 16'h002a);
        wr(ADDR_PROT_B, 16'h0007);
        for (int j = 0; j < 4; j++) begin
            @(posedge i_clk) ol_req <= j % 2 == 0;
            cyc(j == 0 ? 80 : 60);
        end
        rd(ADDR_PROT_B, 16'h0007);
        chk("ol short", 16'h0000, 16'(n_ol));
        for (int k = 0; k < 4; k++) begin
            v = ret[k] | cut[k] | 16'h0003;
            wr(ADDR_PROT_B, v);
            @(posedge i_clk) ol_req <= 1'b1;
            cyc(200);
            chk("ol cut", cexp[k], 16'(o_drive));
            chk("ol halt", 16'h0001, 16'(o_counter_halt));
            rd(ADDR_PROT_B, v | 16'h0010);
            kick(k);
            cyc(3);
            rd(ADDR_PROT_B, v | 16'h0010);
            @(posedge i_clk) ol_req <= 1'b0;
            cyc(10);
            kick(k);
            cyc(3);
            rd(ADDR_PROT_B, ret[k][7] ? v & 16'hff7f : v);
            chk("ol back", 16'h0038, 16'(o_drive));
            chk("ol run", 16'h0000, 16'(o_counter_halt));
        end
        chk("ol irqs", 16'h0004, 16'(n_ol));
        wr(ADDR_PROT_B, 16'h0004);
        @(posedge i_clk) ol_req <= 1'b1;
        cyc(200);
        chk("ol off irq", 16'h0004, 16'(n_ol));
        chk("ol off drv", 16'h0038, 16'(o_drive));
        end_of_test;
    end
endmodule
`default_nettype wire
